// [hw/aur_fifo.sv]
module aur_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 8
) (
	input wire logic i_mclk, // System clock
	input wire logic i_rst, // Synchronous reset
	input wire logic i_in_valid, // Write word offered
	output logic o_in_ready, // Room for a word
	input wire logic [WIDTH-1:0] i_in_data, // Write word
	output logic o_out_valid, // Word available
	input wire logic i_out_ready, // Reader takes word
	output logic [WIDTH-1:0] o_out_data // Head word
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign o_in_ready = (count != (AW+1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem[rd_ptr];

	always_ff @(posedge i_mclk) begin
		if (push)
			mem[wr_ptr] <= i_in_data;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

endmodule

// [hw/aur_rx.sv]
// How it works
// - Sampling runs at 16 ticks per bit, or 8 with double speed set.
// - A high-to-low edge on the idle line starts start-bit checking.
// - The start bit is voted on samples 8-10 (or 4-6), counting from 1.
// - A start vote that comes out high is noise; go back to idle.
// - The falling edge seen while idle resets bit timing, once per frame.
// - Each bit before the stop walks 16 (or 8) sample states numbered by sample_num.
// - Each bit is the majority of its three centre samples.
// - Reception ends at the last vote sample of the first stop bit; further stops ignored.
// - A stop bit that votes zero sets the frame error flag.
// - After the last stop vote sample a new falling edge is accepted.
// - Payload of character plus parity ranges from 5 to 10 bits.
// - The frame error is stored in the buffer with its frame.
// - With parity enabled, parity is checked and stored with the frame.
module aur_rx (
	input wire logic i_mclk, // System clock, 10 MHz
	input wire logic i_rst, // Synchronous reset
	input wire logic i_serial_rx_input, // Asynchronous receive line
	input wire logic i_sample_tick, // Oversampling tick, one cycle
	input wire logic i_rx_enable, // Receiver on; off flushes buffer
	input wire logic i_double_speed_select, // 8 samples per bit
	input wire logic [1:0] i_parity_mode_field, // [1] check, [0] odd
	input wire logic [3:0] i_char_size, // Data bits, 5 to 9
	output logic o_frame_valid, // Received frame ready
	input wire logic i_frame_ready, // Reader takes frame
	output aur_pkg::aur_frame_t o_frame, // Data and error flags
	output logic o_overrun, // Frame dropped, buffer full; pulse
	output logic o_busy // Frame in progress
);

	// ----------------------------------------
	// Line synchroniser and edge detect
	// ----------------------------------------
	logic rx_meta;
	logic rx_sync;
	logic rx_prev;
	logic fall_seen;

	// Both flops reset to the idle level so no false edge follows reset
	// two-stage synchroniser
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end else begin
			rx_meta <= i_serial_rx_input;
			rx_sync <= rx_meta;
		end
	end

	// Edge is judged per tick so that a short glitch between ticks is
	// only seen if it is still low at a sample point.
	always_ff @(posedge i_mclk) begin
		if (i_rst)
			rx_prev <= 1'b1;
		else if (i_sample_tick)
			rx_prev <= rx_sync;
	end

	assign fall_seen = i_sample_tick && rx_prev && !rx_sync;

	// ----------------------------------------
	// Mode constants
	// ----------------------------------------
	logic [4:0] samples_per_bit;
	logic [4:0] vote_first;
	logic [4:0] vote_last;

	// Mode is read live; it must only change while the receiver is idle
	// oversampling rate chosen by mode
	assign samples_per_bit = i_double_speed_select ?
		aur_pkg::SAMPLES_DOUBLE : aur_pkg::SAMPLES_NORMAL;
	assign vote_first = i_double_speed_select ?
		aur_pkg::VOTE_FIRST_DOUBLE : aur_pkg::VOTE_FIRST_NORMAL;
	assign vote_last = vote_first + 5'h02;

	// ----------------------------------------
	// State and sample counter
	// ----------------------------------------
	aur_pkg::aur_state_t state;
	aur_pkg::aur_state_t next_state;
	aur_pkg::aur_phase_t phase;
	logic [4:0] sample_num;
	logic [3:0] bit_num;
	logic in_window;
	logic at_vote_end;
	logic at_bit_end;
	logic vote_value;
	logic frame_done;
	logic char_last;
	logic [3:0] char_size;

	// payload size clamp
	// Out-of-range sizes are clamped so a frame always terminates
	assign char_size = (i_char_size < aur_pkg::CHAR_MIN) ? aur_pkg::CHAR_MIN :
		(i_char_size > aur_pkg::CHAR_MAX) ? aur_pkg::CHAR_MAX : i_char_size;
	assign char_last = (bit_num == char_size - 4'h1);

	// centre three samples feed the vote
	assign in_window = (state != aur_pkg::AUR_IDLE) && i_sample_tick &&
		(sample_num >= vote_first) && (sample_num <= vote_last);
	assign at_vote_end = i_sample_tick && (sample_num == vote_last);
	assign at_bit_end = i_sample_tick && (sample_num == samples_per_bit);

	// ----------------------------------------
	// Majority vote
	// ----------------------------------------
	// The vote is cleared at each bit end, so it only ever holds the three
	// centre samples of the bit in progress.
	aur_vote u_vote (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_clear(at_bit_end || state == aur_pkg::AUR_IDLE),
		.i_take(in_window),
		.i_sample(rx_sync),
		.o_result(vote_value)
	);

	// ----------------------------------------
	// Frame end
	// ----------------------------------------
	// Stop bit vote result is final once its last centre sample is in;
	// the vote module updates one cycle later, so capture then.
	logic stop_vote_due;
	assign frame_done = stop_vote_due;

	always_ff @(posedge i_mclk) begin
		if (i_rst || !i_rx_enable)
			stop_vote_due <= 1'b0;
		else
			stop_vote_due <= (state == aur_pkg::AUR_BITS) &&
				(phase == aur_pkg::AUR_PHASE_STOP) && at_vote_end;
	end

	// ----------------------------------------
	// Receive state machine
	// ----------------------------------------
	// Edges seen while a frame is in progress are ignored; only the idle
	// state looks for a new start.
	always_comb begin
		next_state = state;
		case (state)
			// falling edge while idle starts checking
			aur_pkg::AUR_IDLE: begin
				if (fall_seen)
					next_state = aur_pkg::AUR_START;
			end
			aur_pkg::AUR_START: begin
				if (at_bit_end && vote_value)
					next_state = aur_pkg::AUR_IDLE;
				else if (at_bit_end)
					next_state = aur_pkg::AUR_BITS;
			end
			aur_pkg::AUR_BITS: begin
				// ready for next edge right after stop vote
				if (phase == aur_pkg::AUR_PHASE_STOP && at_vote_end)
					next_state = aur_pkg::AUR_IDLE;
			end
			default: next_state = aur_pkg::AUR_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst || !i_rx_enable)
			state <= aur_pkg::AUR_IDLE;
		else
			state <= next_state;
	end

	// ----------------------------------------
	// Sample counter
	// ----------------------------------------
	// Ticks must be at least two clocks apart: the vote result is only
	// settled one clock after its last sample.
	// counter moves on ticks, reloads sample one when idle
	// each accepted frame restarts bit timing from sample one
	always_ff @(posedge i_mclk) begin
		if (i_rst || !i_rx_enable)
			sample_num <= aur_pkg::SAMPLE_ONE;
		else if (state == aur_pkg::AUR_IDLE)
			sample_num <= fall_seen ? aur_pkg::SAMPLE_ONE + 5'h01 :
				aur_pkg::SAMPLE_ONE;
		else if (at_bit_end)
			sample_num <= aur_pkg::SAMPLE_ONE;
		else if (i_sample_tick)
			sample_num <= sample_num + 5'h01;
	end

	// ----------------------------------------
	// Bit position and shift register
	// ----------------------------------------
	logic [aur_pkg::DATA_W-1:0] shift;
	logic parity_bit;

	// data, then optional parity, then first stop only
	always_ff @(posedge i_mclk) begin
		if (i_rst || state != aur_pkg::AUR_BITS) begin
			phase <= aur_pkg::AUR_PHASE_DATA;
			bit_num <= aur_pkg::BIT_ZERO;
		end else if (at_bit_end) begin
			case (phase)
				aur_pkg::AUR_PHASE_DATA: begin
					bit_num <= bit_num + 4'h1;
					if (char_last)
						phase <= i_parity_mode_field[1] ?
							aur_pkg::AUR_PHASE_PARITY : aur_pkg::AUR_PHASE_STOP;
				end
				aur_pkg::AUR_PHASE_PARITY: phase <= aur_pkg::AUR_PHASE_STOP;
				default: phase <= aur_pkg::AUR_PHASE_STOP;
			endcase
		end
	end

	// Unused upper data bits stay zero from the clear at frame start
	// latch voted bit at the end of its period
	always_ff @(posedge i_mclk) begin
		if (i_rst || state == aur_pkg::AUR_START) begin
			shift <= '0;
			parity_bit <= 1'b0;
		end else if (state == aur_pkg::AUR_BITS && at_bit_end) begin
			if (phase == aur_pkg::AUR_PHASE_DATA)
				shift[bit_num] <= vote_value;
			else if (phase == aur_pkg::AUR_PHASE_PARITY)
				parity_bit <= vote_value;
		end
	end

	// ----------------------------------------
	// Frame result into the buffer
	// ----------------------------------------
	logic parity_calc;
	logic parity_en;
	aur_pkg::aur_frame_t frame_word;
	logic fifo_in_ready;
	logic fifo_out_valid;
	aur_pkg::aur_frame_t fifo_out;

	// ----------------------------------------
	// Parity check
	// ----------------------------------------
	// Parity enable is caught at frame start; the parity phase and odd/even select still read the live mode
	always_ff @(posedge i_mclk) begin
		if (i_rst)
			parity_en <= 1'b0;
		else if (state == aur_pkg::AUR_START)
			parity_en <= i_parity_mode_field[1];
	end

	// parity over data bits, odd or even
	assign parity_calc = (^shift) ^ parity_bit ^ i_parity_mode_field[0];

	always_comb begin
		frame_word.data = shift;
		// stop voted zero gives frame error
		frame_word.frame_error_flag = !vote_value;
		frame_word.parity_error = parity_en && parity_calc;
	end

	// ----------------------------------------
	// Receive buffer
	// ----------------------------------------
	// Eight frames of slack let a slow reader fall behind without loss
	// error flags travel in the buffer with the frame
	aur_fifo #(
		.WIDTH(aur_pkg::FRAME_W),
		.DEPTH(aur_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_mclk(i_mclk),
		.i_rst(i_rst || !i_rx_enable),
		.i_in_valid(frame_done),
		.o_in_ready(fifo_in_ready),
		.i_in_data(frame_word),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(i_frame_ready),
		.o_out_data(fifo_out)
	);

	// ----------------------------------------
	// Overrun
	// ----------------------------------------
	// A full buffer cannot stall the line, so the frame is dropped and
	// reported instead.
	always_ff @(posedge i_mclk) begin
		if (i_rst)
			o_overrun <= 1'b0;
		else
			o_overrun <= frame_done && !fifo_in_ready;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Busy is decoded from both state register bits, and the START to BITS step changes both of them at once
	assign o_frame_valid = fifo_out_valid;
	assign o_frame = fifo_out;
	assign o_busy = (state != aur_pkg::AUR_IDLE);

endmodule

// [hw/aur_vote.sv]
module aur_vote (
	input wire logic i_mclk, // System clock
	input wire logic i_rst, // Synchronous reset
	input wire logic i_clear, // Restart vote
	input wire logic i_take, // Take a sample
	input wire logic i_sample, // Sample value
	output logic o_result // Majority of samples taken
);

	logic [1:0] ones;
	logic [1:0] zeros;

	always_ff @(posedge i_mclk) begin
		if (i_rst || i_clear) begin
			ones <= 2'h0;
			zeros <= 2'h0;
		end else if (i_take) begin
			if (i_sample)
				ones <= ones + 2'h1;
			else
				zeros <= zeros + 2'h1;
		end
	end

	assign o_result = (ones > zeros);

endmodule

// [shared/aur_pkg.sv]
package aur_pkg;

	// ----------------------------------------
	// Oversampling and voting positions
	// ----------------------------------------
	localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
	localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
	localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
	localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
	localparam logic [4:0] SAMPLE_ONE = 5'h01;

	// ----------------------------------------
	// Frame format
	// ----------------------------------------
	localparam int DATA_W = 9;
	localparam logic [3:0] CHAR_MIN = 4'h5;
	localparam logic [3:0] CHAR_MAX = 4'h9;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam int FIFO_DEPTH = 8;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		AUR_IDLE = 2'b00,
		AUR_START = 2'b01,
		AUR_BITS = 2'b10
	} aur_state_t;

	typedef enum logic [1:0] {
		AUR_PHASE_DATA = 2'b00,
		AUR_PHASE_PARITY = 2'b01,
		AUR_PHASE_STOP = 2'b10
	} aur_phase_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic frame_error_flag;
		logic parity_error;
	} aur_frame_t;

	localparam int FRAME_W = $bits(aur_frame_t);

endpackage

// [testbench/async_uart_rx_recovery_test.sv]
module async_uart_rx_recovery_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst, tick, rx_en, dbl, rd_rdy, line, fvalid, ovr, busy;
	logic [1:0] pmode;
	logic [3:0] csize;
	aur_pkg::aur_frame_t frame;
	aur_pkg::aur_frame_t exp_q[$];
	int err_total, check_count, ovr_seen;

	aur_rx dut (.i_mclk(mclk), .i_rst(rst), .i_serial_rx_input(line),
		.i_sample_tick(tick), .i_rx_enable(rx_en),
		.i_double_speed_select(dbl), .i_parity_mode_field(pmode),
		.i_char_size(csize), .o_frame_valid(fvalid),
		.i_frame_ready(rd_rdy), .o_frame(frame), .o_overrun(ovr),
		.o_busy(busy));
	aur_tx_model tx (.i_mclk(mclk), .i_tick(tick), .o_line(line));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Tick every third cycle keeps ticks apart as the receiver needs
	initial begin
		tick = 1'b0;
		forever begin
			repeat (2) @(posedge mclk);
			#1 tick = 1'b1;
			@(posedge mclk);
			#1 tick = 1'b0;
		end
	end
	always @(posedge mclk) if (ovr === 1'b1) ovr_seen++;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk_frame(input aur_pkg::aur_frame_t got, exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH frame t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH flag t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic aur_pkg::aur_frame_t expf(input logic [8:0] d,
		input logic pe, input logic stop);
		aur_pkg::aur_frame_t f;
		f.data = d;
		f.frame_error_flag = ~stop;
		f.parity_error = pe;
		return f;
	endfunction

	// Send one frame and queue what the receiver has to report
	task automatic xfer(input logic bad, input logic stop, input logic short);
		logic [8:0] d;
		logic [9:0] bits;
		int spb;
		spb = dbl ? 8 : 16;
		d = 9'($urandom) & ((9'h1 << csize) - 9'h1);
		bits = {1'b0, d} | (10'(^d ^ pmode[0] ^ bad) << csize);
		exp_q.push_back(expf(d, pmode[1] & bad, stop));
		tx.send(bits, csize + pmode[1], spb, stop, short ? 10 : spb);
	endtask

	task automatic drain();
		int n;
		while (exp_q.size() > 0) begin
			n = 0;
			do begin
				@(posedge mclk);
				#1;
				n++;
				if (n > 4000) begin
					err_total++;
					give_verdict();
				end
			end while (fvalid !== 1'b1);
			chk_frame(frame, exp_q.pop_front());
			rd_rdy = 1'b1;
			@(posedge mclk);
			#1 rd_rdy = 1'b0;
		end
	endtask

	initial begin
		rst = 1'b1;
		rx_en = 1'b1;
		dbl = 1'b0;
		rd_rdy = 1'b0;
		pmode = 2'h0;
		csize = 4'h8;
		err_total = 0;
		check_count = 0;
		ovr_seen = 0;
		void'($urandom(32'h603c));
		repeat (4) @(posedge mclk);
		#1 rst = 1'b0;
		chk_flag(busy, 1'b0);
		chk_flag(fvalid, 1'b0);
		for (int m = 0; m < 2; m++)
			// five to nine data bits, parity adds one
			for (int c = 5; c < 10; c++)
				for (int p = 1; p < 4; p++) begin
					dbl = m[0];
					csize = 4'(c);
					pmode = 2'(p);
					xfer(1'b0, 1'b1, 1'b0);
					drain();
				end
		$display("test sweep done");
		dbl = 1'b0;
		for (int p = 2; p < 4; p++) begin
			pmode = 2'(p);
			xfer(1'b0, 1'b0, 1'b0);
			xfer(1'b1, 1'b1, 1'b0);
			drain();
		end
		$display("test errors done");
		// Low too short to win the start vote in either speed
		for (int m = 0; m < 2; m++) begin
			dbl = m[0];
			tx.hold(1'b0, m ? 4 : 8);
			tx.hold(1'b1, 24);
			#1 chk_flag(busy, 1'b0);
			chk_flag(fvalid, 1'b0);
		end
		$display("test noise done");
		dbl = 1'b0;
		pmode = 2'h0;
		repeat (9) xfer(1'b0, 1'b1, 1'b1);
		void'(exp_q.pop_back());
		repeat (12) @(posedge mclk);
		chk_flag(ovr_seen == 1, 1'b1);
		drain();
		chk_flag(fvalid, 1'b0);
		$display("test overrun done");
		xfer(1'b0, 1'b1, 1'b0);
		repeat (12) @(posedge mclk);
		#1 chk_flag(fvalid, 1'b1);
		rx_en = 1'b0;
		@(posedge mclk);
		#1 chk_flag(fvalid, 1'b0);
		exp_q.delete();
		rx_en = 1'b1;
		xfer(1'b0, 1'b1, 1'b0);
		drain();
		$display("test flush done");
		give_verdict();
	end
endmodule

// [testbench/aur_rx_sva.sv]
module aur_rx_sva (
	input wire logic i_mclk, // System clock
	input wire logic i_rst, // Synchronous reset
	input wire logic i_sample_tick, // Oversampling tick
	input wire logic i_rx_enable, // Receiver on
	input wire logic i_frame_ready, // Reader takes frame
	input wire logic o_frame_valid, // Frame ready
	input wire aur_pkg::aur_frame_t o_frame, // Head frame
	input wire logic o_overrun, // Dropped frame pulse
	input wire logic o_busy // Frame in progress
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	busy_on_tick_a: assert property (
		$rose(o_busy) |-> $past(i_sample_tick)) else $error("busy rose off tick");
	busy_off_tick_a: assert property (
		$fell(o_busy) |-> $past(i_sample_tick) || !$past(i_rx_enable))
		else $error("busy fell off tick");
	busy_hold_a: assert property (
		o_busy && !i_sample_tick && i_rx_enable |=> o_busy)
		else $error("busy moved without tick");
	start_span_a: assert property (
		$rose(o_busy) |-> (o_busy || !i_rx_enable) [*8])
		else $error("start check too short");
	head_hold_a: assert property (
		o_frame_valid && !i_frame_ready && i_rx_enable
		|=> o_frame_valid && $stable(o_frame)) else $error("head frame changed");
	head_drop_a: assert property (
		$fell(o_frame_valid) |-> $past(i_frame_ready) || !$past(i_rx_enable))
		else $error("frame lost without pop");
	push_after_a: assert property (
		$rose(o_frame_valid) |-> !$past(o_busy))
		else $error("frame pushed while busy");
	overrun_pulse_a: assert property (
		o_overrun |=> !o_overrun) else $error("overrun longer than a cycle");
	overrun_full_a: assert property (
		o_overrun |-> $past(o_frame_valid)) else $error("overrun with room");
endmodule

bind aur_rx aur_rx_sva u_sva (.i_mclk, .i_rst, .i_sample_tick, .i_rx_enable,
	.i_frame_ready, .o_frame_valid, .o_frame, .o_overrun, .o_busy);

// [testbench/aur_tx_model.sv]
module aur_tx_model (
	input wire logic i_mclk, // System clock
	input wire logic i_tick, // Oversampling tick
	output logic o_line // Serial line, idles high
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_line = 1'b1;

	// Levels change just after a tick edge, so bit edges stay on tick grid
	task automatic hold(input logic v, input int n);
		#1 o_line = v;
		repeat (n) begin
			do @(posedge i_mclk); while (i_tick !== 1'b1);
		end
	endtask

	// exact rate, payload up to ten bits
	task automatic send(input logic [9:0] bits, input int nb, input int spb,
		input logic stop, input int sl);
		hold(1'b0, spb);
		for (int i = 0; i < nb; i++)
			hold(bits[i], spb);
		hold(stop, sl);
		if (!stop)
			hold(1'b1, spb);
	endtask
endmodule
